// ==== rtl/servo_jog_speed_select.v ====
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "servo_jog_defines.vh"

module servo_jog_speed_select (
  // clock, reset, enable
  input wire clk_sys_i,
  input wire nrst_i,
  input wire ce_i,
  // register port
  input wire [7:0] addr_i,
  input wire [31:0] wr_data_i,
  input wire wr_en_i,
  input wire rd_en_i,
  output reg [31:0] rd_data_o,
  // drive restart pulse, same clock domain
  input wire restart_i,
  // keypad pins
  input wire key_up_i,
  input wire key_down_i,
  input wire key_shift_i,
  input wire key_set_i,
  input wire key_mode_i,
  // digital input pins
  input wire [8:0] din_i,
  // analog command, signed, 0.1 r/min units, same clock domain
  input wire [15:0] analog_cmd_i,
  // drive outputs
  output reg [31:0] speed_cmd_o,
  output reg servo_on_o,
  output reg torque_limit_o,
  output reg jog_active_o,
  output reg [1:0] source_sel_o,
  output reg [2:0] alarm_o
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_EDIT = 2'h1;
  localparam ST_JOG = 2'h2;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg [13:0] pin_meta_r;
  reg [13:0] pin_sync_r;
  reg [4:0] key_prev_r;
  wire [13:0] pin_raw;
  assign pin_raw = {din_i, key_mode_i, key_set_i, key_shift_i,
                    key_down_i, key_up_i};

  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_meta_r <= 14'h0000;
      pin_sync_r <= 14'h0000;
      key_prev_r <= 5'h00;
    end else if (ce_i) begin
      pin_meta_r <= pin_raw;
      pin_sync_r <= pin_meta_r;
      key_prev_r <= pin_sync_r[4:0];
    end
  end

  wire up_lvl = pin_sync_r[0];
  wire down_lvl = pin_sync_r[1];
  wire [4:0] key_edge = pin_sync_r[4:0] & ~key_prev_r;
  wire [8:0] din_s = pin_sync_r[13:5];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg sw_enable_r;
  reg [15:0] jog_speed_r;
  reg [7:0] mode_pend_r;
  reg [7:0] mode_act_r;
  reg [31:0] preset_r [0:2];
  reg [7:0] fcode_r [0:8];
  reg [1:0] state_r;
  reg [15:0] edit_val_r;
  reg [1:0] digit_r;
  reg [2:0] alarm_r;
  reg fault_rst_prev_r;
  integer i;
  integer j;

  wire sel_fc = (addr_i >= `OFS_FCODE_BASE) &&
                (addr_i <= `OFS_FCODE_LAST) && (addr_i[1:0] == 2'h0);
  wire [3:0] fc_idx = addr_i[5:2] - 4'h8;
  wire preset_ok = ($signed(wr_data_i) <= `PRESET_MAX) &&
                   ($signed(wr_data_i) >= `PRESET_MIN);
  wire sel_preset = (addr_i == `OFS_PRESET_ONE) ||
                    (addr_i == `OFS_PRESET_TWO) ||
                    (addr_i == `OFS_PRESET_THREE);
  wire [1:0] preset_idx = (addr_i == `OFS_PRESET_ONE) ? 2'h0 :
                          (addr_i == `OFS_PRESET_TWO) ? 2'h1 : 2'h2;

  // ----------------------------------------------------------------
  // input function decode
  // ----------------------------------------------------------------
  // on: an input holding the code is high; asg: some input holds it
  reg fn_servo, fn_trq, fn_sel0, fn_sel1, fn_fault_rst;
  reg asg_nl, asg_pl, asg_emg, low_nl, low_pl, low_emg;

  always @* begin
    fn_servo = 1'b0;
    fn_trq = 1'b0;
    fn_sel0 = 1'b0;
    fn_sel1 = 1'b0;
    fn_fault_rst = 1'b0;
    asg_nl = 1'b0;
    asg_pl = 1'b0;
    asg_emg = 1'b0;
    low_nl = 1'b0;
    low_pl = 1'b0;
    low_emg = 1'b0;
    for (i = 0; i < 9; i = i + 1) begin
      // code 0 matches nothing, so the input is ignored
      case (fcode_r[i])
        `FC_SERVO_ENABLE: fn_servo = fn_servo | din_s[i];
        `FC_TORQUE_LIMIT: fn_trq = fn_trq | din_s[i];
        `FC_SPEED_BIT0: fn_sel0 = fn_sel0 | din_s[i];
        `FC_SPEED_BIT1: fn_sel1 = fn_sel1 | din_s[i];
        `FC_FAULT_RESET: fn_fault_rst = fn_fault_rst | din_s[i];
        `FC_REV_LIMIT: begin
          asg_nl = 1'b1;
          low_nl = low_nl | ~din_s[i];
        end
        `FC_FWD_LIMIT: begin
          asg_pl = 1'b1;
          low_pl = low_pl | ~din_s[i];
        end
        `FC_EMG_STOP: begin
          asg_emg = 1'b1;
          low_emg = low_emg | ~din_s[i];
        end
        default: begin
        end
      endcase
    end
  end

  // the drive follows the input level, or the software setting
  wire servo_en = sw_enable_r | fn_servo;
  // assigned limit or stop inputs that are not made raise alarms
  wire [2:0] alarm_set = {asg_emg & low_emg, asg_pl & low_pl,
                          asg_nl & low_nl};
  wire alarm_clr = restart_i | (fn_fault_rst & ~fault_rst_prev_r);

  // ----------------------------------------------------------------
  // jog edit step
  // ----------------------------------------------------------------
  reg [15:0] step;
  reg [15:0] edit_nxt;
  always @* begin
    case (digit_r)
      2'h0: step = 16'h0001;
      2'h1: step = 16'h000A;
      2'h2: step = 16'h0064;
      default: step = 16'h03E8;
    endcase
    edit_nxt = edit_val_r;
    if (key_edge[0]) begin
      // saturate instead of wrapping past the display range
      if (edit_val_r > `JOG_MAX - step)
        edit_nxt = `JOG_MAX;
      else
        edit_nxt = edit_val_r + step;
    end else if (key_edge[1]) begin
      if (edit_val_r < step)
        edit_nxt = 16'h0000;
      else
        edit_nxt = edit_val_r - step;
    end
  end

  // ----------------------------------------------------------------
  // control state
  // ----------------------------------------------------------------
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sw_enable_r <= `RST_SW_ENABLE;
      jog_speed_r <= `RST_JOG_SPEED;
      mode_pend_r <= `RST_CTRL_MODE;
      mode_act_r <= `RST_CTRL_MODE;
      for (j = 0; j < 3; j = j + 1)
        preset_r[j] <= `RST_PRESET;
      for (j = 0; j < 9; j = j + 1)
        fcode_r[j] <= `RST_FCODE_OTHER;
      fcode_r[5] <= `RST_FCODE_NL;
      fcode_r[6] <= `RST_FCODE_PL;
      fcode_r[7] <= `RST_FCODE_EMG;
      state_r <= ST_IDLE;
      edit_val_r <= `RST_JOG_SPEED;
      digit_r <= 2'h0;
      alarm_r <= 3'h0;
      fault_rst_prev_r <= 1'b0;
    end else if (ce_i) begin
      fault_rst_prev_r <= fn_fault_rst;
      // a fault present in the clearing cycle stays latched
      alarm_r <= (alarm_r & ~{3{alarm_clr}}) | alarm_set;
      // pending mode moves to active only at a restart
      if (restart_i)
        mode_act_r <= mode_pend_r;
      if (wr_en_i) begin
        if (addr_i == `OFS_SW_ENABLE)
          sw_enable_r <= wr_data_i[0];
        if (addr_i == `OFS_JOG_SPEED)
          jog_speed_r <= wr_data_i[15:0];
        if (addr_i == `OFS_CTRL_MODE)
          mode_pend_r <= wr_data_i[7:0];
        if (sel_preset && preset_ok)
          preset_r[preset_idx] <= wr_data_i;
        if (sel_fc)
          fcode_r[fc_idx] <= wr_data_i[7:0];
      end
      case (state_r)
        ST_IDLE: begin
          if (key_edge[3]) begin
            state_r <= ST_EDIT;
            edit_val_r <= jog_speed_r;
            digit_r <= 2'h0;
          end
        end
        ST_EDIT: begin
          edit_val_r <= edit_nxt;
          if (key_edge[2])
            digit_r <= digit_r + 2'h1;
          if (key_edge[3]) begin
            jog_speed_r <= edit_val_r;
            state_r <= ST_JOG;
          end else if (key_edge[4]) begin
            state_r <= ST_IDLE;
          end
        end
        ST_JOG: begin
          if (key_edge[3])
            jog_speed_r <= edit_val_r;
          if (key_edge[4])
            state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // speed command
  // ----------------------------------------------------------------
  wire [1:0] src_sel = {fn_sel1, fn_sel0};
  wire [31:0] jog_cmd = {16'h0000, jog_speed_r} * `JOG_SCALE;
  wire speed_mode = (mode_act_r == `MODE_SPEED);
  reg [31:0] cmd_nxt;

  always @* begin
    cmd_nxt = 32'h00000000;
    if (!servo_en) begin
      cmd_nxt = 32'h00000000;
    end else if (state_r == ST_JOG) begin
      // clockwise is positive, counterclockwise negative
      if (up_lvl && !down_lvl)
        cmd_nxt = 32'h00000000 - jog_cmd;
      else if (down_lvl && !up_lvl)
        cmd_nxt = jog_cmd;
    end else if (speed_mode) begin
      case (src_sel)
        `SEL_ANALOG:
          cmd_nxt = {{16{analog_cmd_i[15]}}, analog_cmd_i};
        `SEL_PRESET_ONE: cmd_nxt = preset_r[0];
        `SEL_PRESET_TWO: cmd_nxt = preset_r[1];
        default: cmd_nxt = preset_r[2];
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs and read data
  // ----------------------------------------------------------------
  reg [31:0] rd_nxt;
  always @* begin
    rd_nxt = 32'h00000000;
    if (sel_fc)
      rd_nxt = {24'h000000, fcode_r[fc_idx]};
    else if (sel_preset)
      rd_nxt = preset_r[preset_idx];
    else begin
      case (addr_i)
        `OFS_SW_ENABLE: rd_nxt = {31'h00000000, sw_enable_r};
        `OFS_JOG_SPEED: rd_nxt = {16'h0000, jog_speed_r};
        `OFS_CTRL_MODE: rd_nxt = {16'h0000, mode_act_r, mode_pend_r};
        `OFS_STATUS: rd_nxt = {16'h0000, edit_val_r[11:0], 1'b0,
                               alarm_r};
        default: rd_nxt = 32'h00000000;
      endcase
    end
  end

  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_data_o <= 32'h00000000;
      speed_cmd_o <= 32'h00000000;
      servo_on_o <= 1'b0;
      torque_limit_o <= 1'b0;
      jog_active_o <= 1'b0;
      source_sel_o <= `SEL_ANALOG;
      alarm_o <= 3'h0;
    end else if (ce_i) begin
      if (rd_en_i)
        rd_data_o <= rd_nxt;
      speed_cmd_o <= cmd_nxt;
      servo_on_o <= servo_en;
      torque_limit_o <= fn_trq;
      jog_active_o <= (state_r == ST_JOG);
      source_sel_o <= src_sel;
      alarm_o <= alarm_r;
    end
  end

endmodule

// ==== rtl/servo_jog_defines.vh ====
`ifndef SERVO_JOG_DEFINES_VH
`define SERVO_JOG_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_SW_ENABLE 8'h00
`define OFS_JOG_SPEED 8'h04
`define OFS_CTRL_MODE 8'h08
`define OFS_PRESET_ONE 8'h0C
`define OFS_PRESET_TWO 8'h10
`define OFS_PRESET_THREE 8'h14
`define OFS_STATUS 8'h18
`define OFS_FCODE_BASE 8'h20
`define OFS_FCODE_LAST 8'h40

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_SW_ENABLE 1'h0
`define RST_JOG_SPEED 16'h0014
`define RST_CTRL_MODE 8'h00
`define RST_PRESET 32'h00000000
`define RST_FCODE_NL 8'h16
`define RST_FCODE_PL 8'h17
`define RST_FCODE_EMG 8'h15
`define RST_FCODE_OTHER 8'h00

// ----------------------------------------------------------------
// encodings
// ----------------------------------------------------------------
`define MODE_SPEED 8'h02
`define FC_DISABLED 8'h00
`define FC_SERVO_ENABLE 8'h65
`define FC_FAULT_RESET 8'h66
`define FC_TORQUE_LIMIT 8'h6D
`define FC_SPEED_BIT0 8'h72
`define FC_SPEED_BIT1 8'h73
`define FC_EMG_STOP 8'h15
`define FC_REV_LIMIT 8'h16
`define FC_FWD_LIMIT 8'h17

// ----------------------------------------------------------------
// numeric limits, scales and source select codes
// ----------------------------------------------------------------
`define PRESET_MAX 32'sh0000C350
`define PRESET_MIN -32'sh0000C350
`define JOG_MAX 16'h270F
`define JOG_SCALE 32'h0000000A
`define SEL_ANALOG 2'h0
`define SEL_PRESET_ONE 2'h1
`define SEL_PRESET_TWO 2'h2
`define SEL_PRESET_THREE 2'h3

`endif

// ==== test/sjs_checker_sva.sv ====
`timescale 1ns/1ps
module sjs_checker (
  // clock and reset
  input wire clk_sys_i,
  input wire nrst_i,
  // watched inputs
  input wire restart_i,
  input wire key_up_i,
  input wire key_down_i,
  input wire key_set_i,
  input wire key_mode_i,
  input wire [8:0] din_i,
  // watched outputs
  input wire [31:0] speed_cmd_o,
  input wire servo_on_o,
  input wire jog_active_o,
  input wire [1:0] source_sel_o,
  input wire [2:0] alarm_o
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  reg [3:0] set_age_r;
  reg [3:0] quiet_r;
  reg [8:0] din_q_r;
  // a clear needs a restart or a fresh input edge shortly before
  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      set_age_r <= 4'hF;
      quiet_r <= 4'hF;
      din_q_r <= 9'h000;
    end else begin
      din_q_r <= din_i;
      if (key_set_i)
        set_age_r <= 4'h0;
      else if (set_age_r != 4'hF)
        set_age_r <= set_age_r + 4'h1;
      if (restart_i || |(din_i & ~din_q_r))
        quiet_r <= 4'h0;
      else if (quiet_r != 4'hF)
        quiet_r <= quiet_r + 4'h1;
    end
  end

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  AST_ZERO_OFF: assert property (
    !servo_on_o && !$past(servo_on_o) |-> speed_cmd_o == 32'h0)
    else $error("speed command not zero while servo is off");
  AST_JOG_CCW: assert property (
    (jog_active_o && servo_on_o && key_up_i && !key_down_i)[*4]
    |-> $signed(speed_cmd_o) <= 0)
    else $error("up key in jog gave a clockwise command");
  AST_JOG_CW: assert property (
    (jog_active_o && servo_on_o && key_down_i && !key_up_i)[*4]
    |-> $signed(speed_cmd_o) >= 0)
    else $error("down key in jog gave a counterclockwise command");
  AST_JOG_STOP: assert property (
    (jog_active_o && !key_up_i && !key_down_i)[*4]
    |-> speed_cmd_o == 32'h0)
    else $error("jog command not stopped after key release");
  AST_JOG_SCALE: assert property (
    jog_active_o && $past(jog_active_o)
    |-> $signed(speed_cmd_o) % 10 == 0)
    else $error("jog command not a whole number of r/min");
  AST_PRESET_RANGE: assert property (
    source_sel_o != 2'h0 && $stable(source_sel_o) && !jog_active_o
    && !$past(jog_active_o) |-> $signed(speed_cmd_o) <= 50000
    && $signed(speed_cmd_o) >= -50000)
    else $error("preset command outside its range");
  AST_JOG_ENTRY: assert property (
    $rose(jog_active_o) |-> set_age_r <= 4'h8)
    else $error("jog entered without a set key press");
  AST_MODE_EXIT: assert property (
    jog_active_o && $rose(key_mode_i) |-> ##[1:6] !jog_active_o)
    else $error("mode key did not leave jog");
  AST_ALARM_CLEAR: assert property (
    |($past(alarm_o) & ~alarm_o) |-> quiet_r <= 4'h6)
    else $error("alarm cleared without restart or fault reset");
endmodule

bind servo_jog_speed_select sjs_checker i_sjs_checker (.clk_sys_i,
  .nrst_i, .restart_i, .key_up_i, .key_down_i, .key_set_i, .key_mode_i,
  .din_i, .speed_cmd_o, .servo_on_o, .jog_active_o, .source_sel_o,
  .alarm_o);

// ==== test/keypad_io_model.sv ====
`timescale 1ns/1ps
module keypad_io_model (
  // clock
  input wire clk_sys_i,
  // requests from the bench
  input wire [4:0] key_req_i,
  input wire [8:0] din_req_i,
  // pins toward the drive, keys {mode,set,shift,down,up}
  output reg [4:0] key_o,
  output reg [8:0] din_o
);
  initial begin
    key_o = 5'h00;
    din_o = 9'h000;
  end
  // switches move just after an edge and stay put, like real contacts
  always @(posedge clk_sys_i) begin
    key_o <= key_req_i;
    din_o <= din_req_i;
  end
endmodule

// ==== test/servo_jog_speed_select_tb.sv ====
`timescale 1ns/1ps
module servo_jog_speed_select_tb;
  reg clk_sys_i = 1'b0;
  reg nrst_i = 1'b0;
  reg [7:0] addr_i = 8'h00;
  reg [31:0] wr_data_i = 32'h0;
  reg wr_en_i = 1'b0;
  reg rd_en_i = 1'b0;
  reg restart_i = 1'b0;
  reg [4:0] key_req = 5'h00;
  reg [8:0] din_req = 9'h000;
  reg [15:0] analog_cmd_i = 16'hFC18;
  wire [31:0] rd_data_o;
  wire [31:0] speed_cmd_o;
  wire [4:0] key;
  wire [8:0] din;
  wire servo_on_o;
  wire torque_limit_o;
  wire jog_active_o;
  wire [1:0] source_sel_o;
  wire [2:0] alarm_o;
  integer n_mismatch = 0;
  integer n_compared = 0;
  integer cyc = 0;
  integer s;
  reg [7:0] fc [0:8];
  reg [31:0] pre [0:3];

  always #5 clk_sys_i = ~clk_sys_i;

  keypad_io_model i_keypad_io_model (.clk_sys_i(clk_sys_i),
    .key_req_i(key_req), .din_req_i(din_req), .key_o(key), .din_o(din));

  servo_jog_speed_select i_servo_jog_speed_select (.clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i), .ce_i(1'b1), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
    .restart_i(restart_i), .key_up_i(key[0]), .key_down_i(key[1]),
    .key_shift_i(key[2]), .key_set_i(key[3]), .key_mode_i(key[4]),
    .din_i(din), .analog_cmd_i(analog_cmd_i), .speed_cmd_o(speed_cmd_o),
    .servo_on_o(servo_on_o), .torque_limit_o(torque_limit_o),
    .jog_active_o(jog_active_o), .source_sel_o(source_sel_o),
    .alarm_o(alarm_o));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_sys_i);
      wr_en_i <= 1'b1;
      addr_i <= a;
      wr_data_i <= d;
      @(posedge clk_sys_i);
      wr_en_i <= 1'b0;
    end
  endtask

  task rd(input [7:0] a, input [31:0] exp);
    begin
      @(posedge clk_sys_i);
      rd_en_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_sys_i);
      rd_en_i <= 1'b0;
      #1 chk(rd_data_o, exp);
    end
  endtask

  // outputs settle within five edges of a request change
  task wt;
    begin
      repeat (8) @(posedge clk_sys_i);
      #1;
    end
  endtask

  task setdin(input [8:0] v);
    begin
      @(posedge clk_sys_i);
      din_req <= v;
      wt;
    end
  endtask

  task press(input integer k);
    begin
      @(posedge clk_sys_i);
      key_req[k] <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      key_req[k] <= 1'b0;
      wt;
    end
  endtask

  task finish_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  always @(posedge clk_sys_i) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      finish_test;
    end
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    fc[0] = 8'h65; fc[1] = 8'h6D; fc[2] = 8'h72; fc[3] = 8'h73;
    fc[4] = 8'h66; fc[5] = 8'h00; fc[6] = 8'h00; fc[7] = 8'h00;
    fc[8] = 8'h00;
    pre[0] = 32'hFFFFFC18; pre[1] = 32'h00007530;
    pre[2] = 32'h000003E8; pre[3] = 32'hFFFF3CB0;
    repeat (4) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    rd(8'h04, 32'h00000014);
    rd(8'h34, 32'h00000016);
    rd(8'h3C, 32'h00000015);
    rd(8'hFC, 32'h00000000);
    wt;
    chk(alarm_o, 32'h7);
    $display("test reset_values done");
    for (s = 0; s < 9; s = s + 1)
      wr(8'h20 + {s[5:0], 2'b00}, fc[s]);
    setdin(9'h010);
    chk(alarm_o, 32'h0);
    setdin(9'h020);
    chk(alarm_o, 32'h0);
    setdin(9'h002);
    chk(torque_limit_o, 32'h1);
    $display("test input_functions done");
    wr(8'h0C, 32'h00007530);
    wr(8'h10, 32'h000003E8);
    wr(8'h14, 32'hFFFF3CB0);
    wr(8'h0C, 32'h0000C351);
    rd(8'h0C, 32'h00007530);
    rd(8'h14, 32'hFFFF3CB0);
    wr(8'h08, 32'h00000002);
    rd(8'h08, 32'h00000002);
    setdin(9'h00D);
    chk(speed_cmd_o, 32'h0);
    @(posedge clk_sys_i);
    restart_i <= 1'b1;
    @(posedge clk_sys_i);
    restart_i <= 1'b0;
    rd(8'h08, 32'h00000202);
    for (s = 0; s < 4; s = s + 1) begin
      setdin({5'h00, s[1:0], 2'b01});
      chk(source_sel_o, s[1:0]);
      chk(speed_cmd_o, pre[s]);
    end
    setdin(9'h00C);
    chk(servo_on_o, 32'h0);
    chk(speed_cmd_o, 32'h0);
    $display("test speed_mode done");
    setdin(9'h000);
    wr(8'h00, 32'h00000001);
    press(3);
    press(0);
    press(0);
    press(2);
    press(0);
    press(1);
    press(0);
    rd(8'h18, 32'h00000200);
    press(3);
    chk(jog_active_o, 32'h1);
    rd(8'h04, 32'h00000020);
    @(posedge clk_sys_i);
    key_req[0] <= 1'b1;
    wt;
    chk(speed_cmd_o, 32'hFFFFFEC0);
    @(posedge clk_sys_i);
    key_req[0] <= 1'b0;
    wt;
    chk(speed_cmd_o, 32'h0);
    @(posedge clk_sys_i);
    key_req[1] <= 1'b1;
    wt;
    chk(speed_cmd_o, 32'h00000140);
    @(posedge clk_sys_i);
    key_req[1] <= 1'b0;
    wt;
    chk(speed_cmd_o, 32'h0);
    press(4);
    chk(jog_active_o, 32'h0);
    $display("test jog done");
    finish_test;
  end
endmodule
